// ===== hdl/plc_alu_pkg.sv
// Shared constants, types and helpers for the ladder arithmetic/logic block.
// Assumes a single core clock; all users import the whole package.
package plc_alu_pkg;

  localparam int ADDR_W = 16;
  localparam int REG_AW = 4;

  // Function block selector
  typedef enum logic [2:0]
  {
    OP_ADD = 3'h0,
    OP_SUB = 3'h1,
    OP_AND = 3'h2,
    OP_OR  = 3'h3,
    OP_XOR = 3'h4,
    OP_NOT = 3'h5
  } op_t;

  // Sequencer states, one-hot
  typedef enum logic [6:0]
  {
    ST_IDLE   = 7'h01,
    ST_ISSUE  = 7'h02,
    ST_RDWAIT = 7'h04,
    ST_CAPT   = 7'h08,
    ST_CALC   = 7'h10,
    ST_WRITE  = 7'h20,
    ST_FIN    = 7'h40
  } seq_state_t;

  // Operand byte slots: 0/1 first operand, 2/3 second operand
  localparam logic [2:0] BYTE_FIRST = 3'h0;
  localparam logic [2:0] BYTE_NONE = 3'h4;

  // Register offsets and fields
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [REG_AW-1:0] REG_RESULT = 4'h8;
  localparam logic [REG_AW-1:0] REG_COUNT = 4'hc;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_ADD_BIT = 0;
  localparam int STAT_SUB_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // Longest accepted-to-done time: four byte reads, calc, two writes, finish
  localparam int DONE_MAX_CYC = 17;

  // Clip a value to the selected operand width
  function automatic logic [15:0] fitWidth(input logic [15:0] v, input logic wide);
    return wide ? v : {8'h00, v[7:0]};
  endfunction

endpackage

// ===== hdl/plc_alu_if.sv
// Internal carriers: main sequencer to arithmetic core, and to register file.
// Assumes plc_alu_pkg is compiled first.
`timescale 1ns/1ps

interface alu_if;
  import plc_alu_pkg::*;
  op_t op;
  logic wide;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] result;
  logic outOfRange;
  modport client (output op, output wide, output a, output b, input result, input outOfRange);
  modport alu (input op, input wide, input a, input b, output result, output outOfRange);
endinterface

interface reg_if;
  logic enable;
  logic addFlag;
  logic subFlag;
  logic busy;
  logic [15:0] lastResult;
  logic opDone;
  modport regs (output enable, input addFlag, input subFlag, input busy, input lastResult, input opDone);
  modport core (input enable, output addFlag, output subFlag, output busy, output lastResult, output opDone);
endinterface

// ===== hdl/alu_core.sv
// Combinational byte/word arithmetic and bitwise core.
// Assumes operands already clipped to the selected width.
`timescale 1ns/1ps

module alu_core
  import plc_alu_pkg::*;
(
  // Operands and result
  alu_if.alu aluBus
);

  logic [16:0] sum;
  logic [16:0] diff;
  logic [15:0] raw;
  logic over;

  always_comb
  begin
    sum = {1'b0, aluBus.a} + {1'b0, aluBus.b};
    diff = {1'b0, aluBus.a} - {1'b0, aluBus.b};
    raw = aluBus.a;
    over = 1'b0;
    case (aluBus.op)
      OP_ADD:
      begin
        raw = sum[15:0];
        over = aluBus.wide ? sum[16] : sum[8];
      end
      OP_SUB:
      begin
        // Unsigned: a borrow means the difference left the width
        raw = diff[15:0];
        over = diff[16];
      end
      OP_AND: raw = aluBus.a & aluBus.b;
      OP_OR: raw = aluBus.a | aluBus.b;
      OP_XOR: raw = aluBus.a ^ aluBus.b;
      OP_NOT: raw = ~aluBus.a;
      default: raw = aluBus.a;
    endcase
  end

  assign aluBus.result = fitWidth(raw, aluBus.wide);
  assign aluBus.outOfRange = over;

endmodule

// ===== hdl/ctrl_regs.sv
// Software register file: enable control, status, last result, operation count.
// Assumes read data is wanted exactly one cycle after the read strobe.
`timescale 1ns/1ps

module ctrl_regs
  import plc_alu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Core side
  reg_if.regs regBus
);

  typedef struct packed {
    logic enable;
    logic [15:0] count;
    logic [31:0] rdData;
  } regs_t;

  regs_t r;
  regs_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.rdData = 32'h0000_0000;
    if (regWr && regAddr == REG_CTRL)
    begin
      next_r.enable = regWrData[CTRL_ENABLE_BIT];
    end
    if (regBus.opDone)
    begin
      next_r.count = 16'(r.count + 16'h0001);
    end
    if (regRd)
    begin
      if (regAddr == REG_CTRL)
      begin
        next_r.rdData[CTRL_ENABLE_BIT] = r.enable;
      end
      else if (regAddr == REG_STATUS)
      begin
        next_r.rdData[STAT_ADD_BIT] = regBus.addFlag;
        next_r.rdData[STAT_SUB_BIT] = regBus.subFlag;
        next_r.rdData[STAT_BUSY_BIT] = regBus.busy;
      end
      else if (regAddr == REG_RESULT)
      begin
        next_r.rdData[15:0] = regBus.lastResult;
      end
      else if (regAddr == REG_COUNT)
      begin
        next_r.rdData[15:0] = r.count;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.enable <= CTRL_ENABLE_RST;
      r.count <= COUNT_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign regRdData = r.rdData;
  assign regBus.enable = r.enable;

endmodule

// ===== hdl/plc_arith_logic_ops.sv
// Ladder function-block unit: add, subtract, AND, OR, XOR, NOT on 1 or 2 bytes.
// Assumes a byte-wide data memory with one-cycle read latency on the same clock.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module plc_arith_logic_ops
  import plc_alu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Scan sequencer request
  input wire logic reqValid,
  output logic reqReady,
  input wire op_t reqOp,
  input wire logic reqExec,
  input wire logic reqWide,
  input wire logic reqConst,
  input wire logic [15:0] reqConstVal,
  input wire logic [ADDR_W-1:0] reqAddrA,
  input wire logic [ADDR_W-1:0] reqAddrB,
  input wire logic [ADDR_W-1:0] reqAddrC,
  output logic doneStrobe,
  // Result flags
  input wire logic addFlagClear,
  input wire logic subFlagClear,
  output logic addFlag,
  output logic subFlag,
  // Data memory
  output logic memRd,
  output logic memWr,
  output logic [ADDR_W-1:0] memAddr,
  output logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  // Register port
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData
);

  typedef struct packed {
    seq_state_t st;
    op_t op;
    logic exec;
    logic wide;
    logic useB;
    logic [2:0] idx;
    logic [15:0] a;
    logic [15:0] b;
    logic [ADDR_W-1:0] addrA;
    logic [ADDR_W-1:0] addrB;
    logic [ADDR_W-1:0] addrC;
    logic [15:0] result;
    logic addFlag;
    logic subFlag;
    logic memRd;
    logic memWr;
    logic [ADDR_W-1:0] memAddr;
    logic [7:0] memWrData;
    logic done;
  } ctx_t;

  ctx_t ctx;
  ctx_t next_ctx;

  alu_if aluBus ();
  reg_if regBus ();

  alu_core u_alu
  (
    .aluBus(aluBus)
  );

  ctrl_regs u_regs
  (
    .core_clk(core_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .regBus(regBus)
  );

  // Byte address within a 1 or 2 byte field, low byte first
  function automatic logic [ADDR_W-1:0] byteAddr(input logic [ADDR_W-1:0] base, input logic hi);
    return ADDR_W'(base + {{(ADDR_W-1){1'b0}}, hi});
  endfunction

  // Next operand byte to fetch, skipping high bytes in byte mode and a constant operand
  function automatic logic [2:0] nextByte(input logic [2:0] k, input logic wide, input logic useB);
    logic [2:0] n;
    n = 3'(k + 3'h1);
    if (n == 3'h1 && !wide)
    begin
      n = 3'h2;
    end
    if (n == 3'h2 && !useB)
    begin
      n = BYTE_NONE;
    end
    else if (n == 3'h3 && !wide)
    begin
      n = BYTE_NONE;
    end
    return n;
  endfunction

  logic accept;
  logic [2:0] fetchNext;

  // Refusing new work while software holds the block disabled
  assign reqReady = (ctx.st == ST_IDLE) && regBus.enable;
  assign accept = reqValid && reqReady;
  assign fetchNext = nextByte(ctx.idx, ctx.wide, ctx.useB);

  always_comb
  begin
    next_ctx = ctx;
    next_ctx.memRd = 1'b0;
    next_ctx.memWr = 1'b0;
    next_ctx.done = 1'b0;
    case (ctx.st)
      ST_IDLE:
      begin
        if (accept)
        begin
          next_ctx.op = reqOp;
          next_ctx.wide = reqWide;
          next_ctx.exec = reqExec && (reqOp <= OP_NOT);
          // Inversion has no second operand, so the constant choice is ignored
          next_ctx.useB = !reqConst && (reqOp != OP_NOT);
          next_ctx.a = 16'h0000;
          next_ctx.b = reqConst ? fitWidth(reqConstVal, reqWide) : 16'h0000;
          next_ctx.addrA = reqAddrA;
          next_ctx.addrB = reqAddrB;
          next_ctx.addrC = reqAddrC;
          next_ctx.idx = BYTE_FIRST;
          // Not executing: straight to finish, no reads, no writes, flags kept
          next_ctx.st = next_ctx.exec ? ST_ISSUE : ST_FIN;
        end
      end
      ST_ISSUE:
      begin
        next_ctx.memRd = 1'b1;
        next_ctx.memAddr = ctx.idx[1] ? byteAddr(ctx.addrB, ctx.idx[0]) : byteAddr(ctx.addrA, ctx.idx[0]);
        next_ctx.st = ST_RDWAIT;
      end
      ST_RDWAIT:
      begin
        next_ctx.st = ST_CAPT;
      end
      ST_CAPT:
      begin
        case (ctx.idx)
          3'h0: next_ctx.a[7:0] = memRdData;
          3'h1: next_ctx.a[15:8] = memRdData;
          3'h2: next_ctx.b[7:0] = memRdData;
          default: next_ctx.b[15:8] = memRdData;
        endcase
        next_ctx.idx = fetchNext;
        next_ctx.st = (fetchNext == BYTE_NONE) ? ST_CALC : ST_ISSUE;
      end
      ST_CALC:
      begin
        next_ctx.result = aluBus.result;
        if (ctx.op == OP_ADD)
        begin
          next_ctx.addFlag = aluBus.outOfRange;
        end
        if (ctx.op == OP_SUB)
        begin
          next_ctx.subFlag = aluBus.outOfRange;
        end
        next_ctx.idx = BYTE_FIRST;
        next_ctx.st = ST_WRITE;
      end
      ST_WRITE:
      begin
        next_ctx.memWr = 1'b1;
        next_ctx.memAddr = byteAddr(ctx.addrC, ctx.idx[0]);
        next_ctx.memWrData = ctx.idx[0] ? ctx.result[15:8] : ctx.result[7:0];
        next_ctx.idx = 3'h1;
        next_ctx.st = (ctx.idx[0] || !ctx.wide) ? ST_FIN : ST_WRITE;
      end
      ST_FIN:
      begin
        next_ctx.done = 1'b1;
        next_ctx.st = ST_IDLE;
      end
      default:
      begin
        next_ctx.st = ST_IDLE;
      end
    endcase
    // Clear beats a result landing in the same cycle
    if (addFlagClear)
    begin
      next_ctx.addFlag = 1'b0;
    end
    if (subFlagClear)
    begin
      next_ctx.subFlag = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctx <= '0;
      ctx.st <= ST_IDLE;
      ctx.op <= OP_ADD;
    end
    else
    begin
      ctx <= next_ctx;
    end
  end

  assign aluBus.op = ctx.op;
  assign aluBus.wide = ctx.wide;
  assign aluBus.a = fitWidth(ctx.a, ctx.wide);
  assign aluBus.b = fitWidth(ctx.b, ctx.wide);

  // Mask makes the forcing visible in the same cycle the clear rises
  assign addFlag = ctx.addFlag && !addFlagClear;
  assign subFlag = ctx.subFlag && !subFlagClear;
  assign doneStrobe = ctx.done;
  assign memRd = ctx.memRd;
  assign memWr = ctx.memWr;
  assign memAddr = ctx.memAddr;
  assign memWrData = ctx.memWrData;

  assign regBus.addFlag = ctx.addFlag;
  assign regBus.subFlag = ctx.subFlag;
  assign regBus.busy = (ctx.st != ST_IDLE);
  assign regBus.lastResult = ctx.result;
  assign regBus.opDone = ctx.done && ctx.exec;

  chk_write_needs_exec: assert property (
    @(posedge core_clk) disable iff (rst) memWr |-> ctx.exec)
    else $error("memory written without execute");

  chk_add_flag_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    ($changed(ctx.addFlag) && !$past(addFlagClear)) |-> ($past(ctx.st) == ST_CALC && $past(ctx.op) == OP_ADD))
    else $error("add flag moved outside an executing add");

  chk_sub_flag_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    ($changed(ctx.subFlag) && !$past(subFlagClear)) |-> ($past(ctx.st) == ST_CALC && $past(ctx.op) == OP_SUB))
    else $error("sub flag moved outside an executing subtract");

  chk_flag_clear_force: assert property (
    @(posedge core_clk) disable iff (rst) (addFlagClear ##1 addFlagClear) |-> (!ctx.addFlag && !addFlag))
    else $error("add flag not forced low by clear");

  chk_sub_clear_force: assert property (
    @(posedge core_clk) disable iff (rst) (subFlagClear ##1 subFlagClear) |-> (!ctx.subFlag && !subFlag))
    else $error("sub flag not forced low by clear");

  chk_add_flag_value: assert property (
    @(posedge core_clk) disable iff (rst)
    (ctx.st == ST_CALC && ctx.op == OP_ADD && !addFlagClear) |=> ctx.addFlag == $past(aluBus.outOfRange))
    else $error("add flag differs from overflow");

  chk_sub_flag_value: assert property (
    @(posedge core_clk) disable iff (rst)
    (ctx.st == ST_CALC && ctx.op == OP_SUB && !subFlagClear) |=> ctx.subFlag == (ctx.result > $past(aluBus.a)))
    else $error("sub flag differs from borrow");

  chk_write_span: assert property (
    @(posedge core_clk) disable iff (rst)
    memWr |-> (memAddr == ctx.addrC || (ctx.wide && memAddr == byteAddr(ctx.addrC, 1'b1))))
    else $error("write outside the destination field");

  chk_idle_no_access: assert property (
    @(posedge core_clk) disable iff (rst) (accept && !reqExec) |=> (ctx.st == ST_FIN) ##1 (doneStrobe && !memWr))
    else $error("non-executing request did not finish quietly");

  chk_not_no_b: assert property (
    @(posedge core_clk) disable iff (rst) (ctx.op == OP_NOT && ctx.st == ST_ISSUE) |-> !ctx.idx[1])
    else $error("inversion fetched a second operand");

  chk_done_bound: assert property (
    @(posedge core_clk) disable iff (rst) accept |-> ##[1:17] doneStrobe)
    else $error("request not finished in time");

endmodule

// ===== tb/data_mem_model.sv
// Byte-wide data memory standing behind the ladder arithmetic unit.
// Assumes reads answer one cycle after the read pulse, on the same clock.
`timescale 1ns/1ps

module data_mem_model
(
  // Clock
  input wire logic core_clk,
  // Memory port
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData
);
  logic [7:0] mem [0:65535];
  logic [7:0] rdByte = 8'h00;
  logic rdValid = 1'b0;
  int nWrites = 0;

  // Data outside the answer cycle is inverted so stale bytes never look right
  assign memRdData = rdValid ? rdByte : ~rdByte;

  always @(posedge core_clk)
  begin
    rdValid <= memRd;
    if (memRd)
    begin
      rdByte <= mem[memAddr];
    end
    if (memWr)
    begin
      mem[memAddr] <= memWrData;
      nWrites <= nWrites + 1;
    end
  end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the ladder arithmetic/logic unit.
// Assumes the design package and interfaces are compiled first.
`timescale 1ns/1ps

module tb_top
  import plc_alu_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqReady;
  op_t reqOp = OP_ADD;
  logic reqExec = 1'b0;
  logic reqWide = 1'b0;
  logic reqConst = 1'b0;
  logic [15:0] reqConstVal = 16'h0000;
  logic [15:0] reqAddrA = 16'h0000;
  logic [15:0] reqAddrB = 16'h0000;
  logic [15:0] reqAddrC = 16'h0000;
  logic doneStrobe;
  logic addFlagClear = 1'b0;
  logic subFlagClear = 1'b0;
  logic addFlag;
  logic subFlag;
  logic memRd;
  logic memWr;
  logic [15:0] memAddr;
  logic [7:0] memWrData;
  logic [7:0] memRdData;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  int failures = 0;
  int n_compared = 0;
  int w;
  logic [31:0] rd;
  op_t bop [4] = '{OP_AND, OP_OR, OP_XOR, OP_NOT};
  logic [7:0] bexp [4] = '{8'h41, 8'hf7, 8'hb6, 8'h1c};
  op_t aop [6] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOT};

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  plc_arith_logic_ops u_dut (.core_clk(core_clk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
    .reqOp(reqOp), .reqExec(reqExec), .reqWide(reqWide), .reqConst(reqConst), .reqConstVal(reqConstVal),
    .reqAddrA(reqAddrA), .reqAddrB(reqAddrB), .reqAddrC(reqAddrC), .doneStrobe(doneStrobe),
    .addFlagClear(addFlagClear), .subFlagClear(subFlagClear), .addFlag(addFlag), .subFlag(subFlag),
    .memRd(memRd), .memWr(memWr), .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

  data_mem_model u_mem (.core_clk(core_clk), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
    .memWrData(memWrData), .memRdData(memRdData));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && n_compared > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // Read data are only valid in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask

  // Request is held until taken, then done is awaited under a bound
  task automatic req(input op_t op, input logic ex, input logic wd, input logic cn, input logic [15:0] cv,
    input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    int n;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqOp <= op;
    reqExec <= ex;
    reqWide <= wd;
    reqConst <= cn;
    reqConstVal <= cv;
    reqAddrA <= a;
    reqAddrB <= b;
    reqAddrC <= c;
    n = 0;
    @(negedge core_clk);
    while (reqReady !== 1'b1 && n < 50)
    begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    reqValid <= 1'b0;
    n = 0;
    while (doneStrobe !== 1'b1 && n < DONE_MAX_CYC)
    begin
      @(negedge core_clk);
      n++;
    end
    check("doneStrobe", {31'h0, doneStrobe}, 32'h0000_0001);
  endtask

  initial
  begin
    #200000;
    failures++;
    end_sim();
  end

  initial
  begin
    u_mem.mem[16'h0010] = 8'he3;
    u_mem.mem[16'h0020] = 8'h55;
    u_mem.mem[16'h0012] = 8'hf0;
    u_mem.mem[16'h0030] = 8'h34;
    u_mem.mem[16'h0031] = 8'h12;
    u_mem.mem[16'h0040] = 8'h00;
    u_mem.mem[16'h0041] = 8'h0f;
    u_mem.mem[16'h0050] = 8'hff;
    u_mem.mem[16'h0051] = 8'hff;
    u_mem.mem[16'h0060] = 8'h05;
    u_mem.mem[16'h0130] = 8'haa;
    u_mem.mem[16'h0142] = 8'h77;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    reg_read(REG_CTRL, rd);
    check("ctrl", rd, 32'h0000_0001);
    reg_read(REG_STATUS, rd);
    check("status", rd, 32'h0000_0000);
    reg_read(4'h2, rd);
    check("unmapped", rd, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      req(bop[i], 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0010, 16'h0020, 16'h0100 + 16'(i));
      check("bitwise", {24'h0, u_mem.mem[16'h0100 + 16'(i)]}, {24'h0, bexp[i]});
    end
    req(OP_AND, 1'b1, 1'b0, 1'b1, 16'h000f, 16'h0010, 16'h0000, 16'h0110);
    check("and const", {24'h0, u_mem.mem[16'h0110]}, 32'h0000_0003);
    // Constant must be ignored by inversion
    req(OP_NOT, 1'b1, 1'b0, 1'b1, 16'h00ff, 16'h0010, 16'h0000, 16'h0111);
    check("not", {24'h0, u_mem.mem[16'h0111]}, 32'h0000_001c);
    req(OP_ADD, 1'b1, 1'b0, 1'b1, 16'h0020, 16'h0012, 16'h0000, 16'h0120);
    check("add sum", {24'h0, u_mem.mem[16'h0120]}, 32'h0000_0010);
    check("add over", {31'h0, addFlag}, 32'h0000_0001);
    reg_read(REG_STATUS, rd);
    check("status add", rd, 32'h0000_0001);
    w = u_mem.nWrites;
    for (int i = 0; i < 6; i++)
    begin
      req(aop[i], 1'b0, 1'b0, 1'b1, 16'h0001, 16'h0010, 16'h0020, 16'h0130);
      check("idle dest", {24'h0, u_mem.mem[16'h0130]}, 32'h0000_00aa);
      check("idle writes", 32'(u_mem.nWrites), 32'(w));
      check("idle addflag", {31'h0, addFlag}, 32'h0000_0001);
      check("idle subflag", {31'h0, subFlag}, 32'h0000_0000);
    end
    // Undefined operation codes finish without touching memory
    req(op_t'(3'h6), 1'b1, 1'b0, 1'b1, 16'h0001, 16'h0010, 16'h0020, 16'h0130);
    check("reserved dest", {24'h0, u_mem.mem[16'h0130]}, 32'h0000_00aa);
    check("reserved writes", 32'(u_mem.nWrites), 32'(w));
    @(posedge core_clk);
    addFlagClear <= 1'b1;
    @(negedge core_clk);
    check("add clear", {31'h0, addFlag}, 32'h0000_0000);
    // Two sampled edges of clear, so the register itself must be cleared
    repeat (2) @(posedge core_clk);
    addFlagClear <= 1'b0;
    @(negedge core_clk);
    check("add cleared", {31'h0, addFlag}, 32'h0000_0000);
    req(OP_ADD, 1'b1, 1'b1, 1'b0, 16'h0000, 16'h0030, 16'h0040, 16'h0140);
    check("wide sum", {16'h0, u_mem.mem[16'h0141], u_mem.mem[16'h0140]}, 32'h0000_2134);
    check("wide span", {24'h0, u_mem.mem[16'h0142]}, 32'h0000_0077);
    check("add normal", {31'h0, addFlag}, 32'h0000_0000);
    req(OP_ADD, 1'b1, 1'b1, 1'b1, 16'h0001, 16'h0050, 16'h0000, 16'h0150);
    check("wide wrap", {16'h0, u_mem.mem[16'h0151], u_mem.mem[16'h0150]}, 32'h0000_0000);
    check("wide over", {31'h0, addFlag}, 32'h0000_0001);
    req(OP_SUB, 1'b1, 1'b0, 1'b1, 16'h0007, 16'h0060, 16'h0000, 16'h0160);
    check("sub diff", {24'h0, u_mem.mem[16'h0160]}, 32'h0000_00fe);
    check("sub under", {31'h0, subFlag}, 32'h0000_0001);
    @(posedge core_clk);
    subFlagClear <= 1'b1;
    @(negedge core_clk);
    check("sub clear", {31'h0, subFlag}, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    subFlagClear <= 1'b0;
    @(negedge core_clk);
    check("sub cleared", {31'h0, subFlag}, 32'h0000_0000);
    req(OP_SUB, 1'b1, 1'b1, 1'b0, 16'h0000, 16'h0030, 16'h0040, 16'h0170);
    check("sub wide", {16'h0, u_mem.mem[16'h0171], u_mem.mem[16'h0170]}, 32'h0000_0334);
    check("sub normal", {31'h0, subFlag}, 32'h0000_0000);
    reg_read(REG_RESULT, rd);
    check("result", rd & 32'h0000_ffff, 32'h0000_0334);
    reg_read(REG_COUNT, rd);
    check("count", rd & 32'h0000_ffff, 32'h0000_000b);
    // Disabled unit must refuse requests
    reg_write(REG_CTRL, 32'h0000_0000);
    @(negedge core_clk);
    check("ready off", {31'h0, reqReady}, 32'h0000_0000);
    reg_write(REG_CTRL, 32'h0000_0001);
    @(negedge core_clk);
    check("ready on", {31'h0, reqReady}, 32'h0000_0001);
    // Reset in mid-run drops the flags and the operation count
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check("reset addflag", {31'h0, addFlag}, 32'h0000_0000);
    check("reset ready", {31'h0, reqReady}, 32'h0000_0001);
    reg_read(REG_COUNT, rd);
    check("reset count", rd, 32'h0000_0000);
    end_sim();
  end
endmodule
